/* shared/sacs_pkg.sv */
package sacs_pkg;
    // ----------------------------------------------------------------
    // widths and reset values
    // ----------------------------------------------------------------
    localparam int CODE_W = 10;
    localparam int DIV_W = 5;
    localparam logic [4:0] DIV_RST = 5'h1F;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [2:0] SRC_RST = 3'h0;

    // ----------------------------------------------------------------
    // trigger source codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SRC_SW = 3'h0;
    localparam logic [2:0] SRC_TMR0 = 3'h1;
    localparam logic [2:0] SRC_TMR2 = 3'h2;
    localparam logic [2:0] SRC_TMR1 = 3'h3;
    localparam logic [2:0] SRC_PIN = 3'h4;
    localparam logic [2:0] SRC_TMR3 = 3'h5;

    // ----------------------------------------------------------------
    // sequence lengths in sar clocks (10-bit mode, 8-bit ends earlier)
    // ----------------------------------------------------------------
    localparam logic [4:0] END_DLY_10 = 5'h11;
    localparam logic [4:0] END_NODLY_10 = 5'h0E;
    localparam logic [4:0] SHORT_8 = 5'h02;
    localparam logic [4:0] TRACK_EXTRA = 5'h03;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TRACK = 3'b010,
        ST_CONV = 3'b100
    } sacs_state_t;
endpackage : sacs_pkg

/* shared/sacs_core_if.sv */
interface sacs_core_if;
    logic sar_tick;
    logic [4:0] divider;
    logic enable;
    logic [2:0] src;
    logic sw_start;
    logic tmr0_ovf;
    logic tmr1_ovf;
    logic tmr2_lo_ovf;
    logic tmr2_hi_ovf;
    logic tmr2_16bit;
    logic tmr3_lo_ovf;
    logic tmr3_hi_ovf;
    logic tmr3_16bit;
    logic pin_rise;
    logic trigger;

    modport div_m (input divider, input enable, output sar_tick);
    modport trig_m (input enable, input src, input sw_start, input tmr0_ovf, input tmr1_ovf,
        input tmr2_lo_ovf, input tmr2_hi_ovf, input tmr2_16bit, input tmr3_lo_ovf,
        input tmr3_hi_ovf, input tmr3_16bit, input pin_rise, output trigger);
    modport top_m (output divider, output enable, output src, output sw_start,
        output tmr0_ovf, output tmr1_ovf, output tmr2_lo_ovf, output tmr2_hi_ovf,
        output tmr2_16bit, output tmr3_lo_ovf, output tmr3_hi_ovf, output tmr3_16bit,
        output pin_rise, input sar_tick, input trigger);
endinterface : sacs_core_if

/* hdl/sacs_clk_div.sv */
module sacs_clk_div (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    sacs_core_if.div_m bus
);
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic wrap;

    // ----------------------------------------------------------------
    // sar clock enable: one pulse per divider+1 system clocks
    // ----------------------------------------------------------------
    assign wrap = (cnt_r >= bus.divider);
    assign cnt_nxt = wrap ? 5'h00 : cnt_r + 5'h01;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= 5'h00;
            bus.sar_tick <= 1'b0;
        end else if (!bus.enable) begin
            // divider held still in shutdown to save power
            cnt_r <= 5'h00;
            bus.sar_tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            bus.sar_tick <= wrap;
        end
    end
endmodule : sacs_clk_div

/* hdl/sacs_trig_sel.sv */
module sacs_trig_sel (
    sacs_core_if.trig_m bus
);
    // ----------------------------------------------------------------
    // trigger source mux
    // ----------------------------------------------------------------
    wire logic tmr2_ovf = bus.tmr2_16bit ? bus.tmr2_hi_ovf : bus.tmr2_lo_ovf;
    wire logic tmr3_ovf = bus.tmr3_16bit ? bus.tmr3_hi_ovf : bus.tmr3_lo_ovf;
    logic sel;

    always_comb begin
        sel = 1'b0;
        case (bus.src)
            sacs_pkg::SRC_SW: sel = bus.sw_start;
            sacs_pkg::SRC_TMR0: sel = bus.tmr0_ovf;
            sacs_pkg::SRC_TMR2: sel = tmr2_ovf;
            sacs_pkg::SRC_TMR1: sel = bus.tmr1_ovf;
            sacs_pkg::SRC_PIN: sel = bus.pin_rise;
            sacs_pkg::SRC_TMR3: sel = tmr3_ovf;
            default: sel = 1'b0;
        endcase
    end

    assign bus.trigger = sel & bus.enable;
endmodule : sacs_trig_sel

/* hdl/sacs_sequencer.sv */
module sacs_sequencer (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic converter_enable_i,
    input wire logic delayed_track_select_i,
    input wire logic left_justify_select_i,
    input wire logic eight_bit_mode_select_i,
    input wire logic [4:0] sar_clock_divider_i,
    input wire logic [2:0] start_source_select_i,
    input wire logic busy_write_one_i,
    input wire logic done_flag_clear_i,
    input wire logic tmr0_ovf_i,
    input wire logic tmr1_ovf_i,
    input wire logic tmr2_lo_ovf_i,
    input wire logic tmr2_hi_ovf_i,
    input wire logic tmr2_16bit_i,
    input wire logic tmr3_lo_ovf_i,
    input wire logic tmr3_hi_ovf_i,
    input wire logic tmr3_16bit_i,
    input wire logic external_start_input_i,
    input wire logic [9:0] sar_code_i,
    input wire logic conv_irq_enable_i,
    output logic conversion_busy_o,
    output logic conversion_done_flag_o,
    output logic conv_irq_o,
    output logic tracking_o,
    output logic converting_o,
    output logic sample_hold_o,
    output logic [7:0] result_high_byte_o,
    output logic [7:0] result_low_byte_o
);
    sacs_core_if core_if ();

    // ----------------------------------------------------------------
    // external start pin synchroniser
    // ----------------------------------------------------------------
    logic [2:0] pin_sync_r;
    logic pin_level_r;
    logic pin_rise_r;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_sync_r <= 3'h0;
            pin_level_r <= 1'b0;
            pin_rise_r <= 1'b0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], external_start_input_i};
            // change counts only when stages two and three agree
            if (pin_sync_r[1] == pin_sync_r[2]) begin
                pin_level_r <= pin_sync_r[2];
            end
            pin_rise_r <= (pin_sync_r[1] == pin_sync_r[2]) & pin_sync_r[2] & ~pin_level_r;
        end
    end

    // ----------------------------------------------------------------
    // sub-block wiring
    // ----------------------------------------------------------------
    assign core_if.divider = sar_clock_divider_i;
    assign core_if.enable = converter_enable_i;
    assign core_if.src = start_source_select_i;
    assign core_if.sw_start = busy_write_one_i;
    assign core_if.tmr0_ovf = tmr0_ovf_i;
    assign core_if.tmr1_ovf = tmr1_ovf_i;
    assign core_if.tmr2_lo_ovf = tmr2_lo_ovf_i;
    assign core_if.tmr2_hi_ovf = tmr2_hi_ovf_i;
    assign core_if.tmr2_16bit = tmr2_16bit_i;
    assign core_if.tmr3_lo_ovf = tmr3_lo_ovf_i;
    assign core_if.tmr3_hi_ovf = tmr3_hi_ovf_i;
    assign core_if.tmr3_16bit = tmr3_16bit_i;
    assign core_if.pin_rise = pin_rise_r;

    sacs_clk_div u_div (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .bus(core_if.div_m)
    );

    sacs_trig_sel u_trig (
        .bus(core_if.trig_m)
    );

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    sacs_pkg::sacs_state_t state_r;
    sacs_pkg::sacs_state_t state_nxt;
    logic [4:0] clk_cnt_r;
    logic [4:0] clk_cnt_nxt;
    logic dly_r;
    logic mode8_r;
    logic busy_r;
    logic done_r;
    logic irq_r;
    logic track_r;
    logic conv_r;
    logic [7:0] hi_r;
    logic [7:0] lo_r;

    wire logic tick = core_if.sar_tick;
    // a trigger while busy or disabled falls through unheard
    wire logic start = core_if.trigger & ~busy_r & converter_enable_i;
    wire logic [4:0] end_10 = dly_r ? sacs_pkg::END_DLY_10 : sacs_pkg::END_NODLY_10;
    wire logic [4:0] end_cnt = mode8_r ? end_10 - sacs_pkg::SHORT_8 : end_10;
    wire logic last_clk = tick & (clk_cnt_r == end_cnt);
    wire logic track_done = tick & (clk_cnt_r == sacs_pkg::TRACK_EXTRA);
    // reserved codes track like the internal sources
    wire logic src_pin = (start_source_select_i == sacs_pkg::SRC_PIN);

    // ----------------------------------------------------------------
    // result formatting
    // ----------------------------------------------------------------
    wire logic [7:0] fmt_hi = eight_bit_mode_select_i ? sar_code_i[9:2]
        : left_justify_select_i ? sar_code_i[9:2]
        : {6'h00, sar_code_i[9:8]};
    wire logic [7:0] fmt_lo = eight_bit_mode_select_i ? 8'h00
        : left_justify_select_i ? {sar_code_i[1:0], 6'h00}
        : sar_code_i[7:0];

    always_comb begin
        state_nxt = state_r;
        clk_cnt_nxt = clk_cnt_r;
        unique case (state_r)
            sacs_pkg::ST_IDLE: begin
                if (start) begin
                    clk_cnt_nxt = 5'h01;
                    state_nxt = delayed_track_select_i ? sacs_pkg::ST_TRACK : sacs_pkg::ST_CONV;
                end
            end
            sacs_pkg::ST_TRACK: begin
                if (tick) begin
                    clk_cnt_nxt = clk_cnt_r + 5'h01;
                end
                if (track_done) begin
                    state_nxt = sacs_pkg::ST_CONV;
                end
            end
            sacs_pkg::ST_CONV: begin
                if (tick) begin
                    clk_cnt_nxt = clk_cnt_r + 5'h01;
                end
                if (last_clk) begin
                    state_nxt = sacs_pkg::ST_IDLE;
                    clk_cnt_nxt = 5'h00;
                end
            end
        endcase
        if (!converter_enable_i) begin
            state_nxt = sacs_pkg::ST_IDLE;
            clk_cnt_nxt = 5'h00;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= sacs_pkg::ST_IDLE;
            clk_cnt_r <= 5'h00;
            dly_r <= 1'b0;
            mode8_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            clk_cnt_r <= clk_cnt_nxt;
            if (start) begin
                // delay and 8-bit length frozen per conversion; mid-run writes wait
                dly_r <= delayed_track_select_i;
                mode8_r <= eight_bit_mode_select_i;
            end
        end
    end

    // ----------------------------------------------------------------
    // busy, done and results
    // ----------------------------------------------------------------
    wire logic finishing = (state_r == sacs_pkg::ST_CONV) & last_clk & converter_enable_i;
    wire logic busy_fall = busy_r & (state_nxt == sacs_pkg::ST_IDLE);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            irq_r <= 1'b0;
            hi_r <= sacs_pkg::BYTE_RST;
            lo_r <= sacs_pkg::BYTE_RST;
        end else begin
            busy_r <= (state_nxt != sacs_pkg::ST_IDLE);
            if (busy_fall) begin
                done_r <= 1'b1;
            end else if (done_flag_clear_i) begin
                done_r <= 1'b0;
            end
            irq_r <= busy_fall & conv_irq_enable_i;
            if (finishing) begin
                hi_r <= fmt_hi;
                lo_r <= fmt_lo;
            end
        end
    end

    // ----------------------------------------------------------------
    // analog core steering
    // ----------------------------------------------------------------
    // pin source without delay: track only while pin low, else hold
    wire logic idle_track = (src_pin & ~delayed_track_select_i) ? ~pin_level_r : 1'b1;
    wire logic track_nxt = converter_enable_i & ((state_nxt == sacs_pkg::ST_IDLE) ? idle_track
        : (state_nxt == sacs_pkg::ST_TRACK));
    wire logic conv_nxt = converter_enable_i & (state_nxt == sacs_pkg::ST_CONV);

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            track_r <= 1'b0;
            conv_r <= 1'b0;
        end else begin
            track_r <= track_nxt;
            conv_r <= conv_nxt;
        end
    end

    assign conversion_busy_o = busy_r;
    assign conversion_done_flag_o = done_r;
    assign conv_irq_o = irq_r;
    assign tracking_o = track_r;
    assign converting_o = conv_r;
    assign sample_hold_o = conv_r;
    assign result_high_byte_o = hi_r;
    assign result_low_byte_o = lo_r;
endmodule : sacs_sequencer

/* verif/sacs_seq_assertions.sv */
module sacs_seq_assertions (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic converter_enable_i,
    input wire logic left_justify_select_i,
    input wire logic eight_bit_mode_select_i,
    input wire logic [2:0] start_source_select_i,
    input wire logic conv_irq_enable_i,
    input wire logic conversion_busy_o,
    input wire logic conversion_done_flag_o,
    input wire logic conv_irq_o,
    input wire logic tracking_o,
    input wire logic converting_o,
    input wire logic sample_hold_o,
    input wire logic [7:0] result_high_byte_o,
    input wire logic [7:0] result_low_byte_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // sequencer properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    property p_off;
        !converter_enable_i ##1 !converter_enable_i |-> !conversion_busy_o;
    endproperty
    a_off: assert property (p_off) else $error("busy while disabled");
    property p_done;
        $fell(conversion_busy_o) |-> conversion_done_flag_o;
    endproperty
    a_done: assert property (p_done) else $error("done flag not set");
    property p_irq;
        $fell(conversion_busy_o) && conv_irq_enable_i |-> conv_irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_irq_one;
        conv_irq_o |-> $fell(conversion_busy_o) && conv_irq_enable_i ##1 !conv_irq_o;
    endproperty
    a_irq_one: assert property (p_irq_one) else $error("stray irq");
    property p_rj;
        $fell(conversion_busy_o) && converter_enable_i && !eight_bit_mode_select_i
            && !left_justify_select_i |-> result_high_byte_o[7:2] == 6'h00;
    endproperty
    a_rj: assert property (p_rj) else $error("high byte padding");
    property p_lj;
        $fell(conversion_busy_o) && converter_enable_i && !eight_bit_mode_select_i
            && left_justify_select_i |-> result_low_byte_o[5:0] == 6'h00;
    endproperty
    a_lj: assert property (p_lj) else $error("low byte padding");
    property p_8b;
        $fell(conversion_busy_o) && converter_enable_i && eight_bit_mode_select_i
            |-> result_low_byte_o == 8'h00;
    endproperty
    a_8b: assert property (p_8b) else $error("low byte in 8-bit mode");
    property p_hold;
        !conversion_busy_o ##1 !conversion_busy_o |-> $stable(result_high_byte_o)
            && $stable(result_low_byte_o);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved while idle");
    property p_track;
        (converter_enable_i && !conversion_busy_o && !start_source_select_i[2])[*2]
            |-> tracking_o;
    endproperty
    a_track: assert property (p_track) else $error("not tracking while idle");
    property p_conv;
        (converting_o || sample_hold_o) |-> conversion_busy_o && !tracking_o;
    endproperty
    a_conv: assert property (p_conv) else $error("convert outside busy");
    c_8b: cover property ($fell(conversion_busy_o) && eight_bit_mode_select_i);
    c_lj: cover property ($fell(conversion_busy_o) && left_justify_select_i);
    c_irq: cover property (conv_irq_o);
endmodule : sacs_seq_assertions

/* verif/sacs_core_model.sv */
module sacs_core_model (
    input wire logic sys_clk_i,
    input wire logic converting_i,
    input wire logic [9:0] level_i,
    output logic [9:0] sar_code_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // analog core stand-in
    // ----------------------------------------------------------------
    logic [9:0] junk_r = 10'h0F0;
    // churns outside conversion so a late sample cannot pass by luck
    always_ff @(posedge sys_clk_i) begin
        junk_r <= ~junk_r;
    end
    assign sar_code_o = converting_i ? level_i : junk_r;
endmodule : sacs_core_model

/* verif/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // harness
    // ----------------------------------------------------------------
    `define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
$display("unexpected %s expected %h seen %h", nm, e, g); end end
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    // cf: 0 enable, 1 delay, 2 left, 3 eight, 4 t2 wide, 5 t3 wide, 6 irq
    logic [6:0] cf = 7'h00;
    // tp: 0 sw, 1 t0, 2 t2 lo, 3 t2 hi, 4 t1, 5 t3 lo, 6 t3 hi, 7 pin
    logic [7:0] tp = 8'h00;
    logic [4:0] div = 5'h00;
    logic [2:0] src = 3'h0;
    logic dclr = 1'b0;
    logic [9:0] lvl = 10'h000;
    logic [9:0] code;
    logic busy, done, irq, trk, cnv;
    logic [7:0] hi, lo;
    logic [2:0] s_t [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h2, 3'h5};
    logic [7:0] g_t [7] = '{8'h02, 8'h04, 8'h10, 8'h80, 8'h20, 8'h08, 8'h40};
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    int l10, l8, len, n;
    sacs_sequencer i_dut (.sys_clk_i(clk), .arst_n_i(rst_n), .converter_enable_i(cf[0]),
        .delayed_track_select_i(cf[1]), .left_justify_select_i(cf[2]),
        .eight_bit_mode_select_i(cf[3]), .sar_clock_divider_i(div),
        .start_source_select_i(src), .busy_write_one_i(tp[0]), .done_flag_clear_i(dclr),
        .tmr0_ovf_i(tp[1]), .tmr1_ovf_i(tp[4]), .tmr2_lo_ovf_i(tp[2]), .tmr2_hi_ovf_i(tp[3]),
        .tmr2_16bit_i(cf[4]), .tmr3_lo_ovf_i(tp[5]), .tmr3_hi_ovf_i(tp[6]),
        .tmr3_16bit_i(cf[5]), .external_start_input_i(tp[7]), .sar_code_i(code),
        .conv_irq_enable_i(cf[6]), .conversion_busy_o(busy), .conversion_done_flag_o(done),
        .conv_irq_o(irq), .tracking_o(trk), .converting_o(cnv), .sample_hold_o(),
        .result_high_byte_o(hi), .result_low_byte_o(lo));
    sacs_core_model i_core (.sys_clk_i(clk), .converting_i(cnv), .level_i(lvl),
        .sar_code_o(code));
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic setc(input logic [6:0] c, input logic [2:0] s, input logic [4:0] d,
        input logic [9:0] v);
        @(posedge clk);
        cf <= c;
        src <= s;
        div <= d;
        lvl <= v;
    endtask : setc
    task automatic kick;
        @(posedge clk);
        tp <= 8'h01;
        @(posedge clk);
        tp <= 8'h00;
    endtask : kick
    // length in system clocks; only differences are judged, phase cancels out
    task automatic run(input logic [7:0] m, output int len);
        int w;
        w = 0;
        len = 0;
        @(posedge clk);
        tp <= m;
        @(posedge clk);
        // pin needs a held level to pass its filter; other strobes stay one cycle
        tp <= m & 8'h80;
        #1;
        while (busy !== 1'b1 && w < 12) begin
            tick(1);
            w++;
        end
        while (busy === 1'b1 && len < 2000) begin
            tick(1);
            len++;
        end
        if (m[7]) begin
            @(posedge clk);
            tp <= 8'h00;
        end
    endtask : run
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        `CHK("busy", 1'b0, busy)
        run(8'h01, len);
        `CHK("disabled start", 0, len)
        setc(7'h01, 3'h0, 5'h00, 10'h3FF);
        run(8'h01, l10);
        `CHK("done", 1'b1, done)
        `CHK("no irq", 1'b0, irq)
        `CHK("right", 16'h03FF, {hi, lo})
        @(posedge clk);
        dclr <= 1'b1;
        @(posedge clk);
        dclr <= 1'b0;
        tick(1);
        `CHK("done clear", 1'b0, done)
        setc(7'h4D, 3'h0, 5'h00, 10'h2A5);
        run(8'h01, l8);
        `CHK("8-bit gain", 2, l10 - l8)
        `CHK("8-bit", 16'hA900, {hi, lo})
        `CHK("irq", 1'b1, irq)
        setc(7'h43, 3'h0, 5'h00, 10'h3FF);
        run(8'h01, len);
        `CHK("delay", 3, len - l10)
        setc(7'h4B, 3'h0, 5'h00, 10'h3FF);
        run(8'h01, n);
        `CHK("delay 8-bit", 3, n - l8)
        `CHK("delay gain", 2, len - n)
        setc(7'h45, 3'h0, 5'h00, 10'h200);
        run(8'h01, len);
        `CHK("left half", 16'h8000, {hi, lo})
        setc(7'h45, 3'h0, 5'h00, 10'h3FF);
        run(8'h01, len);
        `CHK("left full", 16'hFFC0, {hi, lo})
        for (int i = 0; i < 7; i++) begin
            setc(i > 4 ? 7'h71 : 7'h41, s_t[i], 5'h00, 10'h3FF);
            run(~g_t[i], len);
            `CHK("wrong source", 0, len)
            run(g_t[i], len);
            `CHK("source", l10, len)
        end
        for (int s = 6; s < 8; s++) begin
            setc(7'h41, s[2:0], 5'h00, 10'h3FF);
            run(8'hFF, len);
            `CHK("reserved", 0, len)
        end
        setc(7'h41, 3'h0, 5'h00, 10'h155);
        kick();
        repeat (3) @(posedge clk);
        kick();
        run(8'h00, len);
        `CHK("retrigger", l10 - 7, len)
        `CHK("result", 16'h0155, {hi, lo})
        setc(7'h41, 3'h0, 5'h00, 10'h2AA);
        kick();
        repeat (5) @(posedge clk);
        cf <= 7'h40;
        tick(2);
        `CHK("abort busy", 1'b0, busy)
        `CHK("abort keep", 16'h0155, {hi, lo})
        setc(7'h41, 3'h0, 5'h03, 10'h3FF);
        run(8'h01, len);
        `CHK("divided", 1'b1, (len - l10) inside {[39:48]})
        setc(7'h41, 3'h4, 5'h00, 10'h3FF);
        @(posedge clk);
        tp <= 8'h80;
        tick(40);
        `CHK("pin high", 1'b0, trk)
        @(posedge clk);
        tp <= 8'h00;
        tick(8);
        `CHK("pin low", 1'b1, trk)
        setc(7'h43, 3'h4, 5'h00, 10'h3FF);
        @(posedge clk);
        tp <= 8'h80;
        tick(40);
        `CHK("pin delayed", 1'b1, trk)
        stop_test();
    end
endmodule : tb_top
bind sacs_sequencer sacs_seq_assertions i_chk (.*);
